// File: core/lcd_column_driver.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - One display byte sampled per falling shift clock edge while enabled.
// - Falling latch pulse moves captured line to latch; all outputs change.
// - Direction select low: first enable pin input, second output; high swaps.
// - Latch pulse returns the chain enable output high.
// - After 160 bits the chain enable output goes low by itself.
// - Direction low: first byte bit 7 drives output one; high reverses.
// - Byte placement follows position in this driver's own sequence.
// - Forced blank low drives every output to the bottom level.
// - Otherwise, with soft blank bit set, level comes from latched bit and frame signal.
// - While disabled the internal data bus is held low, bytes ignored.
module lcd_column_driver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic display_shift_clock,
    input wire logic line_latch_pulse,
    input wire logic [7:0] display_byte_bus,
    input wire logic direction_select,
    input wire logic ac_frame_signal,
    input wire logic forced_blank_n,
    input wire logic chain_enable_first_in,
    output logic chain_enable_first_out,
    output logic chain_enable_first_oe,
    input wire logic chain_enable_second_in,
    output logic chain_enable_second_out,
    output logic chain_enable_second_oe,
    output lcd_pkg::lcd_level_type [159:0] segment_outputs
);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] bit_reverse(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < lcd_pkg::BYTE_BITS; i++) begin
            r[i] = b[lcd_pkg::BYTE_BITS - 1 - i];
        end
        return r;
    endfunction

    function automatic lcd_pkg::lcd_level_type pick_level(
        input logic blank_n, input logic bit_on, input logic frame);
        lcd_pkg::lcd_level_type l;
        l = lcd_pkg::LEVEL_BOTTOM;
        if (blank_n) begin
            if (bit_on) begin
                l = frame ? lcd_pkg::LEVEL_TOP : lcd_pkg::LEVEL_BOTTOM;
            end else begin
                l = frame ? lcd_pkg::LEVEL_UPPER_MID
                          : lcd_pkg::LEVEL_LOWER_MID;
            end
        end
        return l;
    endfunction

    // ==========================================================
    // Core state
    logic shift_prev_q, shift_prev_d;
    logic latch_prev_q, latch_prev_d;
    logic [4:0] count_q, count_d;
    logic chain_out_q, chain_out_d;
    logic first_oe_q, first_oe_d;
    logic second_oe_q, second_oe_d;
    logic [159:0] column_q, column_d;
    logic [159:0] latch_q, latch_d;
    lcd_pkg::lcd_level_type [159:0] seg_q, seg_d;
    logic [15:0] lines_q, lines_d;
    logic soft_blank_n_q, soft_blank_n_d;

    logic shift_fall, latch_fall, enable_in, loading, capture;
    logic [7:0] inner_bus;
    logic blank_n;

    always_comb begin
        shift_fall = shift_prev_q & ~display_shift_clock;
        latch_fall = latch_prev_q & ~line_latch_pulse;
        enable_in = direction_select ? chain_enable_second_in
                                     : chain_enable_first_in;
        // Active low enable; stop once our own line is full
        loading = ~enable_in & (count_q < lcd_pkg::BYTES_PER_LINE);
        // Held low when idle so nothing toggles downstream
        inner_bus = loading ? display_byte_bus : 8'h00;
        // Latch pulse wins; a byte on the same cycle is dropped
        capture = shift_fall & loading & ~latch_fall;
        blank_n = forced_blank_n & soft_blank_n_q;

        shift_prev_d = display_shift_clock;
        latch_prev_d = line_latch_pulse;
        count_d = count_q;
        chain_out_d = chain_out_q;
        column_d = column_q;
        latch_d = latch_q;
        lines_d = lines_q;
        first_oe_d = direction_select;
        second_oe_d = ~direction_select;

        if (latch_fall) begin
            count_d = lcd_pkg::COUNT_RESET;
            chain_out_d = 1'b1;
            lines_d = lines_q + 16'h0001;
            for (int i = 0; i < lcd_pkg::COLUMNS; i++) begin
                // Mirror ordering when direction is high
                latch_d[i] = direction_select
                    ? column_q[lcd_pkg::COLUMNS - 1 - i] : column_q[i];
            end
        end else if (capture) begin
            // Slot chosen by own byte count, not edge count
            column_d[int'(count_q) * lcd_pkg::BYTE_BITS +: 8] =
                bit_reverse(inner_bus);
            count_d = count_q + 5'h01;
            if (count_q == lcd_pkg::BYTES_PER_LINE - 5'h01) begin
                chain_out_d = 1'b0;
            end
        end

        for (int i = 0; i < lcd_pkg::COLUMNS; i++) begin
            seg_d[i] = pick_level(blank_n, latch_q[i],
                                  ac_frame_signal);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
            count_q <= lcd_pkg::COUNT_RESET;
            chain_out_q <= lcd_pkg::CHAIN_OUT_RESET;
            first_oe_q <= 1'b0;
            second_oe_q <= 1'b0;
            column_q <= '0;
            latch_q <= '0;
            seg_q <= {lcd_pkg::COLUMNS{lcd_pkg::LEVEL_BOTTOM}};
            lines_q <= lcd_pkg::LINES_RESET;
        end else begin
            shift_prev_q <= shift_prev_d;
            latch_prev_q <= latch_prev_d;
            count_q <= count_d;
            chain_out_q <= chain_out_d;
            first_oe_q <= first_oe_d;
            second_oe_q <= second_oe_d;
            column_q <= column_d;
            latch_q <= latch_d;
            seg_q <= seg_d;
            lines_q <= lines_d;
        end
    end

    // Both pins carry the same level; only the enabled one drives
    assign chain_enable_first_out = chain_out_q;
    assign chain_enable_second_out = chain_out_q;
    assign chain_enable_first_oe = first_oe_q;
    assign chain_enable_second_oe = second_oe_q;
    assign segment_outputs = seg_q;

    // ==========================================================
    // APB slave, one wait-free access phase
    lcd_pkg::lcd_status_type status;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic hit;

    always_comb begin
        status.direction = direction_select;
        status.chain_out = chain_out_q;
        status.loading = loading;
        status.byte_count = count_q;
        hit = (paddr == lcd_pkg::CTRL_OFFSET)
            | (paddr == lcd_pkg::STATUS_OFFSET)
            | (paddr == lcd_pkg::LINES_OFFSET);
        ready_d = psel & ~penable;
        err_d = psel & ~penable & ~hit;
        rdata_d = 32'h0000_0000;
        soft_blank_n_d = soft_blank_n_q;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                lcd_pkg::CTRL_OFFSET:
                    rdata_d[lcd_pkg::CTRL_SOFT_BLANK_N_BIT] = soft_blank_n_q;
                lcd_pkg::STATUS_OFFSET: begin
                    rdata_d[lcd_pkg::STATUS_COUNT_LSB +: 5] =
                        status.byte_count;
                    rdata_d[lcd_pkg::STATUS_LOADING_BIT] = status.loading;
                    rdata_d[lcd_pkg::STATUS_CHAIN_OUT_BIT] =
                        status.chain_out;
                    rdata_d[lcd_pkg::STATUS_DIRECTION_BIT] =
                        status.direction;
                end
                lcd_pkg::LINES_OFFSET:
                    rdata_d[15:0] = lines_q;
                default:
                    rdata_d = 32'h0000_0000;
            endcase
        end
        if (psel && penable && ready_q && pwrite
            && paddr == lcd_pkg::CTRL_OFFSET) begin
            soft_blank_n_d = pwdata[lcd_pkg::CTRL_SOFT_BLANK_N_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            soft_blank_n_q <= lcd_pkg::CTRL_SOFT_BLANK_N_RESET;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
            soft_blank_n_q <= soft_blank_n_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

    // ==========================================================
    // Checks
    byte_capture_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture |=> count_q == $past(count_q) + 5'h01)
        else $error("byte not counted on shift clock fall");

    latch_xfer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        latch_fall && !direction_select |=> latch_q == $past(column_q))
        else $error("line not transferred on latch fall");

    enable_dir_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        direction_select ##1 direction_select |->
            chain_enable_first_oe && !chain_enable_second_oe)
        else $error("enable pin roles wrong for direction");

    enable_rearm_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        latch_fall |=> chain_enable_first_out && chain_enable_second_out)
        else $error("chain enable not re-armed by latch");

    enable_done_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture && count_q == lcd_pkg::BYTES_PER_LINE - 5'h01 |=>
            !chain_out_q ##1 (!chain_out_q || $past(latch_fall)))
        else $error("chain enable not low after full line");

    first_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture && count_q == 5'h00 |=>
            column_q[0] == $past(display_byte_bus[7]))
        else $error("first byte bit 7 misplaced");

    idle_ignore_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !loading && !latch_fall |=> $stable(column_q))
        else $error("data captured while disabled");

    count_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        latch_fall |=> count_q == 5'h00 && loading == !enable_in)
        else $error("byte counter not cleared by latch");

    blank_bottom_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !forced_blank_n |=>
            segment_outputs == {160{lcd_pkg::LEVEL_BOTTOM}})
        else $error("forced blank did not drive bottom level");

    level_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        blank_n && !latch_q[0] && ac_frame_signal |=>
            segment_outputs[0] == lcd_pkg::LEVEL_UPPER_MID)
        else $error("clear bit with frame high not upper mid");

    mirror_xfer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        latch_fall && direction_select |=>
            latch_q[0] == $past(column_q[lcd_pkg::COLUMNS - 1]))
        else $error("mirrored line not reversed on latch fall");

    enable_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !chain_out_q && !latch_fall |=> !chain_out_q)
        else $error("chain enable rose without latch pulse");

    ready_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("bus ready held longer than one cycle");

    ctrl_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite
            && paddr == lcd_pkg::CTRL_OFFSET |=>
            soft_blank_n_q == $past(pwdata[lcd_pkg::CTRL_SOFT_BLANK_N_BIT]))
        else $error("control write did not land");

endmodule

// File: core/lcd_pkg.sv
package lcd_pkg;

    // ==========================================================
    // Line geometry
    localparam int COLUMNS = 160;
    localparam int BYTE_BITS = 8;
    localparam logic [4:0] BYTES_PER_LINE = 5'h14;

    // ==========================================================
    // Drive levels of a segment output
    typedef enum logic [1:0] {
        LEVEL_TOP = 2'h0,
        LEVEL_UPPER_MID = 2'h1,
        LEVEL_LOWER_MID = 2'h2,
        LEVEL_BOTTOM = 2'h3
    } lcd_level_type;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] LINES_OFFSET = 12'h008;

    // Control fields
    localparam int CTRL_SOFT_BLANK_N_BIT = 0;
    localparam logic CTRL_SOFT_BLANK_N_RESET = 1'b1;

    // Status fields
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_LOADING_BIT = 8;
    localparam int STATUS_CHAIN_OUT_BIT = 9;
    localparam int STATUS_DIRECTION_BIT = 10;

    // Reset values
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic CHAIN_OUT_RESET = 1'b1;
    localparam logic [15:0] LINES_RESET = 16'h0000;

    // ==========================================================
    // Status word carried to the bus slave
    typedef struct packed {
        logic direction;
        logic chain_out;
        logic loading;
        logic [4:0] byte_count;
    } lcd_status_type;

endpackage

// File: verification/lcd_column_driver_tb_top.sv
`timescale 1ns/1ps
module lcd_column_driver_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, sclk, lp;
    logic [7:0] bus;
    logic dir = 1'b0;
    logic frame = 1'b1;
    logic blank_n = 1'b0;
    logic en_n = 1'b1;
    logic f_in, f_out, f_oe, s_in, s_out, s_oe;
    lcd_pkg::lcd_level_type [159:0] segs;
    logic [159:0] line = '0;
    int bad_count = 0;
    int checks = 0;

    // Only the pin chosen as input sees the upstream enable
    assign f_in = dir ? f_out : en_n;
    assign s_in = dir ? en_n : s_out;

    always #5 pclk = ~pclk;

    lcd_ctrl_model lcd_ctrl_model_inst (.pclk(pclk),
        .display_shift_clock(sclk), .line_latch_pulse(lp),
        .display_byte_bus(bus));

    lcd_column_driver lcd_column_driver_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .display_shift_clock(sclk), .line_latch_pulse(lp),
        .display_byte_bus(bus), .direction_select(dir),
        .ac_frame_signal(frame), .forced_blank_n(blank_n),
        .chain_enable_first_in(f_in), .chain_enable_first_out(f_out),
        .chain_enable_first_oe(f_oe), .chain_enable_second_in(s_in),
        .chain_enable_second_out(s_out), .chain_enable_second_oe(s_oe),
        .segment_outputs(segs));

    task automatic results();
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
            bad_count++;
        end
    endtask

    // ==========================================
    // APB master
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
            input logic [31:0] mask);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat & mask, exp);
    endtask

    task automatic send_bytes(input int first, input int last,
            input logic [7:0] s);
        logic [7:0] b;
        for (int k = first; k <= last; k++) begin
            b = 8'(k * 29) ^ s;
            for (int j = 0; j < 8; j++) begin
                line[k * 8 + 7 - j] = b[j];
            end
            lcd_ctrl_model_inst.send_byte(b);
        end
    endtask

    task automatic seg_chk(input logic d, input logic f, input logic bl);
        lcd_pkg::lcd_level_type e;
        int c;
        repeat (3) @(posedge pclk);
        for (int i = 0; i < lcd_pkg::COLUMNS; i++) begin
            c = d ? 159 - i : i;
            if (!bl) begin
                e = lcd_pkg::LEVEL_BOTTOM;
            end else if (line[c]) begin
                e = f ? lcd_pkg::LEVEL_TOP : lcd_pkg::LEVEL_BOTTOM;
            end else begin
                e = f ? lcd_pkg::LEVEL_UPPER_MID : lcd_pkg::LEVEL_LOWER_MID;
            end
            chk(32'(segs[i]), 32'(e));
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Panel held blank until the drive supply is taken as settled
        seg_chk(1'b0, 1'b1, 1'b0);
        blank_n <= 1'b1;
        seg_chk(1'b0, 1'b1, 1'b1);
        rdc(lcd_pkg::CTRL_OFFSET, 32'h0000_0001, 32'hffff_ffff);
        rdc(lcd_pkg::STATUS_OFFSET, 32'h0000_0200, 32'hffff_feff);
        rdc(12'h00c, 32'h0000_0000, 32'hffff_ffff);
        chk(32'(rerr), 32'h0000_0001);
        @(posedge pclk);
        chk(32'(pready), 32'h0000_0000);
        chk(32'({f_oe, s_oe}), 32'h0000_0001);
        send_bytes(0, 1, 8'h77);
        rdc(lcd_pkg::STATUS_OFFSET, 32'h0000_0200, 32'hffff_feff);
        en_n <= 1'b0;
        send_bytes(0, 18, 8'h5a);
        rdc(lcd_pkg::STATUS_OFFSET, 32'h0000_0213, 32'hffff_feff);
        send_bytes(19, 19, 8'h5a);
        repeat (2) @(posedge pclk);
        chk(32'({f_out, s_out}), 32'h0000_0000);
        rdc(lcd_pkg::STATUS_OFFSET, 32'h0000_0014, 32'hffff_feff);
        lcd_ctrl_model_inst.send_byte(8'hff);
        lcd_ctrl_model_inst.latch_line();
        seg_chk(1'b0, 1'b1, 1'b1);
        chk(32'({f_out, s_out}), 32'h0000_0003);
        rdc(lcd_pkg::LINES_OFFSET, 32'h0000_0001, 32'hffff_ffff);
        frame <= 1'b0;
        seg_chk(1'b0, 1'b0, 1'b1);
        blank_n <= 1'b0;
        seg_chk(1'b0, 1'b0, 1'b0);
        blank_n <= 1'b1;
        apb(1'b1, lcd_pkg::CTRL_OFFSET, 32'h0000_0000);
        seg_chk(1'b0, 1'b0, 1'b0);
        apb(1'b1, lcd_pkg::CTRL_OFFSET, 32'h0000_0001);
        dir <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'({f_oe, s_oe}), 32'h0000_0002);
        send_bytes(0, 19, 8'hc3);
        lcd_ctrl_model_inst.latch_line();
        frame <= 1'b1;
        seg_chk(1'b1, 1'b1, 1'b1);
        rdc(lcd_pkg::STATUS_OFFSET, 32'h0000_0600, 32'hffff_feff);
        results();
    end
endmodule

// File: verification/lcd_ctrl_model.sv
`timescale 1ns/1ps
module lcd_ctrl_model (
    input wire logic pclk,
    output logic display_shift_clock,
    output logic line_latch_pulse,
    output logic [7:0] display_byte_bus
);
    initial begin
        display_shift_clock = 1'b0;
        line_latch_pulse = 1'b0;
        display_byte_bus = 8'h00;
    end

    // ==========================================
    // One byte per shift clock fall
    task automatic send_byte(input logic [7:0] b);
        @(posedge pclk);
        display_shift_clock <= 1'b1;
        display_byte_bus <= ~b;
        @(posedge pclk);
        display_shift_clock <= 1'b0;
        display_byte_bus <= b;
        @(posedge pclk);
        // Released bus shows the inverse so a late sample cannot pass
        display_byte_bus <= ~b;
    endtask

    task automatic latch_line();
        @(posedge pclk);
        line_latch_pulse <= 1'b1;
        @(posedge pclk);
        line_latch_pulse <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
